//--- test/sensor_checker.sv
// assertion checker for the sensor flag, mode and reply-enable outputs
`default_nettype none
module sensor_checker (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic spi_cs_n,
  input wire logic spi_miso_oe_n,
  input wire logic int_out,
  input wire logic meas_done,
  input wire logic wake_exceed,
  input wire logic mode_continuous,
  input wire logic mode_wake,
  input wire logic mode_single,
  input wire logic meas_start,
  input wire logic link_ready
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] cs_hi;
  wire logic  any_mode;
  assign any_mode = mode_continuous | mode_wake | mode_single;
  // flags may only drop during or shortly after a frame, so count idle select cycles
  always_ff @(posedge ref_clk)
    if (!rst_n || !spi_cs_n)
      cs_hi <= 4'h0;
    else if (cs_hi != 4'hF)
      cs_hi <= cs_hi + 4'h1;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  a_quiet_early: assert property (
    !link_ready |-> spi_miso_oe_n && !any_mode)
    else $error("activity before link ready");
  a_ready_holds: assert property (
    link_ready |=> link_ready) else $error("link ready dropped");
  a_mode_onehot: assert property (
    $onehot0({mode_continuous, mode_wake, mode_single}))
    else $error("two modes active");
  a_no_jump: assert property (
    $changed({mode_continuous, mode_wake, mode_single})
      |-> !$past(any_mode) || !any_mode)
    else $error("mode changed without idle");
  a_start_pulse: assert property (
    $rose(any_mode) |-> (##[0:1] meas_start) or $past(meas_start))
    else $error("mode entered without start");
  a_single_done: assert property (
    ce && mode_single && meas_done |-> ##[1:2] (!mode_single && int_out))
    else $error("single measurement not finished");
  a_cont_done: assert property (
    ce && mode_continuous && meas_done |-> ##[1:2] int_out)
    else $error("continuous result not flagged");
  a_wake_set: assert property (
    ce && mode_wake && wake_exceed |-> ##[1:2] int_out)
    else $error("wake exceed not flagged");
  a_wake_quiet: assert property (
    mode_wake && !int_out && !wake_exceed && !$past(wake_exceed)
      |=> !int_out)
    else $error("wake flag without exceed");
  a_int_clear: assert property (
    $fell(int_out) |-> cs_hi < 4'h8)
    else $error("interrupt dropped outside a frame end");
  a_cont_exit: assert property (
    $fell(mode_continuous) |-> cs_hi < 4'h8)
    else $error("continuous mode left without command");
  c_cont: cover property (mode_continuous && meas_done);
  c_wake: cover property (mode_wake && wake_exceed);
  c_clear: cover property ($fell(int_out));
endmodule
bind sensor_status_register_access sensor_checker u_chk (
  .ref_clk, .rst_n, .ce, .spi_cs_n, .spi_miso_oe_n, .int_out, .meas_done,
  .wake_exceed, .mode_continuous, .mode_wake, .mode_single, .meas_start,
  .link_ready);
`default_nettype wire

//--- test/spi_host_model.sv
// host controller model: mode 3 frames, most significant bit first
`default_nettype none
module spi_host_model (
  output logic     spi_cs_n,
  output logic     spi_sclk,
  output logic     spi_mosi,
  input wire logic spi_miso_out,
  input wire logic spi_miso_oe_n
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam real HALF = 62.5;
  wire logic miso;
  // released line is held high by the board pull-up
  assign miso = spi_miso_oe_n ? 1'b1 : spi_miso_out;
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b1;
    spi_mosi = 1'b1;
  end
  task automatic xfer(input int n, input logic [47:0] tx,
                      output logic [47:0] rx);
    rx = '0;
    spi_cs_n = 1'b0;
    #(HALF);
    for (int i = 0; i < n * 8; i++) begin
      spi_sclk = 1'b0;
      spi_mosi = tx[47 - i];
      #(HALF);
      spi_sclk = 1'b1;
      rx = {rx[46:0], miso};
      #(HALF);
    end
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    #(HALF * 2);
  endtask
endmodule
`default_nettype wire

//--- test/testbench.sv
// self-checking bench for the sensor register and flag block
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        ref_clk, rst_n, trig_pin, meas_done, wake_exceed, ce;
  logic [15:0] angle_data, field_data, d;
  logic [47:0] rx;
  logic [7:0]  st;
  int          fails = 0, n_compared = 0, i;
  wire logic   spi_cs_n, spi_sclk, spi_mosi, spi_miso_out, spi_miso_oe_n;
  wire logic   int_out, mode_continuous, mode_wake, mode_single;
  wire logic   meas_start, link_ready;
  wire logic [15:0] angle_threshold_value;
  wire logic [1:0]  oversample_select;
  wire logic [2:0]  filter_control;
  wire logic [3:0]  channel_gate_select;
  wire logic [5:0]  interval_count, device_address;
  wire logic [14:0] angle_zero;
  wire logic [51:0] cfg;
  // reserved bits and unmapped places must read back as zero
  logic [5:0]  ra [8] = '{6'h0A, 6'h19, 6'h1C, 6'h1D, 6'h1E, 6'h06,
                          6'h07, 6'h1F};
  logic [15:0] rm [8] = '{16'h003F, 16'hFFFF, 16'h0607, 16'h03FF,
                          16'h7FFF, 16'h0000, 16'h0000, 16'h0000};
  assign cfg = {angle_threshold_value, oversample_select, filter_control,
                channel_gate_select, interval_count, angle_zero,
                device_address};
  sensor_status_register_access #(.INIT_CYCLES(20'd20)) u_dut (
    .ref_clk, .rst_n, .ce, .spi_cs_n, .spi_sclk, .spi_mosi,
    .trig_pin, .spi_miso_out, .spi_miso_oe_n, .int_out, .meas_done,
    .wake_exceed, .angle_data, .field_data, .mode_continuous, .mode_wake,
    .mode_single, .meas_start, .link_ready, .angle_threshold_value,
    .oversample_select, .filter_control, .channel_gate_select,
    .interval_count, .angle_zero, .device_address);
  spi_host_model u_host (
    .spi_cs_n, .spi_sclk, .spi_mosi, .spi_miso_out, .spi_miso_oe_n);
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic check(input string what, input logic [63:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic rd(input logic [5:0] a);
    u_host.xfer(4, {8'h50, a, 2'b00, 32'h0}, rx);
    st = rx[23:16];
    d = rx[15:0];
  endtask
  task automatic cmd(input logic [7:0] op);
    u_host.xfer(2, {op, 40'h0}, rx);
    st = rx[7:0];
  endtask
  task automatic rddata(input logic [7:0] exp_st);
    u_host.xfer(6, {8'h40, 40'h0}, rx);
    check("data status", rx[39:32], exp_st);
    check("angle", rx[31:16], angle_data);
    check("field", rx[15:0], field_data);
    repeat (6) @(posedge ref_clk);
    check("int cleared", int_out, 1'b0);
  endtask
  // k selects meas_done, wake_exceed or trig_pin
  task automatic pulse(input int k, input int len);
    @(posedge ref_clk) #1;
    {trig_pin, wake_exceed, meas_done} = 3'b001 << k;
    repeat (len) @(posedge ref_clk);
    #1 {trig_pin, wake_exceed, meas_done} = 3'b000;
    repeat (6) @(posedge ref_clk);
  endtask
  initial begin
    repeat (40000) @(posedge ref_clk);
    fails++;
    print_verdict();
  end
  initial begin
    {rst_n, trig_pin, wake_exceed, meas_done} = 4'h0;
    ce = 1'b1;
    angle_data = 16'h1000;
    field_data = 16'hA55A;
    repeat (10) @(posedge ref_clk);
    #1 rst_n = 1'b1;
    // frame starts inside the quiet time and must be ignored
    u_host.xfer(1, {8'h10, 40'h0}, rx);
    check("early frame", mode_continuous, 1'b0);
    check("link ready", link_ready, 1'b1);
    for (i = 0; i < 8; i++) begin
      u_host.xfer(4, {8'h60, 16'hFFFF, ra[i], 2'b00, 16'h0000}, rx);
      check("wr status", rx[23:16], 8'h00);
      rd(ra[i]);
      check("rd status", st, 8'h00);
      check("rd data", d, rm[i]);
    end
    check("config", cfg, {52{1'b1}});
    for (i = 1; i <= 3; i++) begin
      cmd({i[3:0], 4'h0});
      check("mode", st, 8'h80 >> (i - 1));
      cmd(8'h10);
      check("reject", st, (8'h80 >> (i - 1)) | 8'h10);
      if (i == 1) begin
        rd(6'h19);
        check("access err", st, 8'h90);
        pulse(0, 1);
        check("cont int", int_out, 1'b1);
        rddata(8'h81);
        // a result pulse while the clock enable is low must go unseen
        @(posedge ref_clk) #1 ce = 1'b0;
        pulse(0, 1);
        #1 ce = 1'b1;
        check("ce freeze", int_out, 1'b0);
      end
      cmd(8'h80);
    end
    pulse(2, 4);
    check("trig single", mode_single, 1'b1);
    pulse(0, 1);
    check("single end", mode_single, 1'b0);
    check("single int", int_out, 1'b1);
    rddata(8'h01);
    cmd(8'h20);
    pulse(0, 1);
    check("wake no exceed", int_out, 1'b0);
    pulse(1, 1);
    check("wake int", int_out, 1'b1);
    rddata(8'h41);
    cmd(8'h80);
    u_host.xfer(2, {8'hF0, 40'h0}, rx);
    check("no reply", rx[15:0], 16'hFFFF);
    rd(6'h19);
    check("reset done", st, 8'h02);
    check("reset cfg", cfg, 52'h0);
    rd(6'h19);
    check("reset once", st, 8'h00);
    print_verdict();
  end
endmodule
`default_nettype wire

//--- verilog/link_sampler.v
// two-flop synchronisers with edge detection for the serial pins
`default_nettype none

module link_sampler #(
  parameter       W       = 4,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input  wire         ref_clk,
  input  wire         rst_n,
  input  wire         ce,
  input  wire [W-1:0] pins,
  output wire [W-1:0] level,
  output wire [W-1:0] rise,
  output wire [W-1:0] fall
);

  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      reg meta;
      reg sync;
      reg last;
      always @(posedge ref_clk) begin
        if (!rst_n) begin
          meta <= RST_VAL[i];
          sync <= RST_VAL[i];
          last <= RST_VAL[i];
        end else if (ce) begin
          meta <= pins[i];
          sync <= meta;
          last <= sync;
        end
      end
      // edges come from the second and third stage only
      assign level[i] = sync;
      assign rise[i]  = ce & sync & ~last;
      assign fall[i]  = ce & ~sync & last;
    end
  endgenerate

endmodule

`default_nettype wire

//--- verilog/sensor_regs_defs.vh
// register map, field positions, command codes and timing constants
`ifndef SENSOR_REGS_DEFS_VH
`define SENSOR_REGS_DEFS_VH

// register indices; the link carries index << 2
`define REG_CHIP_STATUS          6'h06
`define REG_ADDRESS_SETTING      6'h0A
`define REG_ANGLE_THRESHOLD      6'h19
`define REG_ADC_SAMPLING_CONTROL 6'h1C
`define REG_MEASUREMENT_SCHEDULE 6'h1D
`define REG_ANGLE_OFFSET         6'h1E
`define ADDR_SHIFT               2

// chip_status bit positions
`define ST_RESULT_AVAIL  0
`define ST_RESET_DONE    1
`define ST_CMD_ERROR     4
`define ST_SINGLE        5
`define ST_WAKE          6
`define ST_CONTINUOUS    7

// field positions
`define ADDR_SET_MSB     5
`define ADDR_SET_LSB     0
`define OSR_MSB          10
`define OSR_LSB          9
`define FILT_MSB         2
`define FILT_LSB         0
`define INTERVAL_MSB     5
`define INTERVAL_LSB     0
`define GATE_MSB         9
`define GATE_LSB         6
`define ZERO_MSB         14
`define ZERO_LSB         0

// reset values
`define RST_ADDR_SET     6'h00
`define RST_THRESHOLD    16'h0000
`define RST_OSR          2'h0
`define RST_FILT         3'h0
`define RST_GATE         4'h0
`define RST_INTERVAL     6'h00
`define RST_ZERO         15'h0000

// command opcodes in the upper nibble of the first byte
`define CMD_CONTINUOUS   4'h1
`define CMD_WAKE         4'h2
`define CMD_SINGLE       4'h3
`define CMD_READ_DATA    4'h4
`define CMD_READ_REG     4'h5
`define CMD_WRITE_REG    4'h6
`define CMD_EXIT         4'h8
`define CMD_RESET        4'hF

// power-up quiet time: 4 ms of 125 MHz cycles, sized to the counter
`define INIT_CYCLES      20'd500000
`define INIT_CNT_W       20

`endif

//--- verilog/sensor_status_register_access.v
// host-facing register bank, command decode and flag logic of the sensor
`include "sensor_regs_defs.vh"
`default_nettype none

module sensor_status_register_access #(
  parameter [`INIT_CNT_W-1:0] INIT_CYCLES = `INIT_CYCLES
) (
  input  wire        ref_clk,
  input  wire        rst_n,
  input  wire        ce,
  input  wire        spi_cs_n,
  input  wire        spi_sclk,
  input  wire        spi_mosi,
  input  wire        trig_pin,
  output wire        spi_miso_out,
  output wire        spi_miso_oe_n,
  output wire        int_out,
  input  wire        meas_done,
  input  wire        wake_exceed,
  input  wire [15:0] angle_data,
  input  wire [15:0] field_data,
  output reg         mode_continuous,
  output reg         mode_wake,
  output reg         mode_single,
  output reg         meas_start,
  output wire        link_ready,
  output reg  [15:0] angle_threshold_value,
  output reg  [1:0]  oversample_select,
  output reg  [2:0]  filter_control,
  output reg  [3:0]  channel_gate_select,
  output reg  [5:0]  interval_count,
  output reg  [14:0] angle_zero,
  output reg  [5:0]  device_address
);

  localparam [1:0] ST_INIT = 2'b01;
  localparam [1:0] ST_RUN  = 2'b10;

  wire [3:0] lvl;
  wire [3:0] rise;
  wire [3:0] fall;

  link_sampler #(
    .W       (4),
    .RST_VAL (4'h3)
  ) u_sampler (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .ce      (ce),
    .pins    ({trig_pin, spi_mosi, spi_sclk, spi_cs_n}),
    .level   (lvl),
    .rise    (rise),
    .fall    (fall)
  );

  reg  [1:0]             state;
  reg  [`INIT_CNT_W-1:0] init_cnt;
  reg  [2:0]             bit_cnt;
  reg  [2:0]             byte_idx;
  reg  [6:0]             rx_sh;
  reg  [7:0]             cmd;
  reg  [7:0]             wdata_hi;
  reg  [15:0]            wdata;
  reg                    ignore;
  reg                    reply_en;
  reg  [7:0]             stat_snap;
  reg  [15:0]            word0;
  reg  [15:0]            word1;
  reg  [7:0]             tx_sh;
  reg                    miso_q;
  reg                    cmd_err;
  reg                    reset_done;
  reg                    result_avail;

  reg                    next_cont;
  reg                    next_wake;
  reg                    next_single;
  reg                    next_err;
  reg                    next_reset_done;
  reg                    next_avail;
  reg                    next_start;
  reg  [7:0]             tx_sel;
  reg  [15:0]            rd_word;

  wire running   = state[1];
  wire cs_act    = running & ~lvl[0];
  wire byte_done = cs_act & rise[1] & (bit_cnt == 3'd7);
  wire [7:0] rx_byte = {rx_sh, lvl[2]};
  wire cs_end    = running & rise[0];
  wire [3:0] op  = cmd[7:4];
  wire [3:0] new_op = rx_byte[7:4];
  // a frame begun inside the quiet window keeps ignore set to its end
  wire cmd_byte  = byte_done & (byte_idx == 3'd0) & ~ignore;
  wire any_mode  = mode_continuous | mode_wake | mode_single;

  wire new_meas = (new_op == `CMD_CONTINUOUS) | (new_op == `CMD_WAKE) |
                  (new_op == `CMD_SINGLE);
  wire new_reg  = (new_op == `CMD_READ_REG) | (new_op == `CMD_WRITE_REG);
  wire new_known = new_meas | new_reg | (new_op == `CMD_READ_DATA) |
                   (new_op == `CMD_EXIT) | (new_op == `CMD_RESET);
  wire reject   = (new_meas & any_mode) |
                  (new_reg & mode_continuous) |
                  ~new_known;
  wire take_cmd = cmd_byte & ~reject;
  wire trig_req = running & rise[3];
  wire trig_rej = trig_req & any_mode;
  wire reset_apply = cs_end & (op == `CMD_RESET) & ~ignore &
                     (byte_idx != 3'd0);
  // a data read counts once the status byte and the first three data bytes were clocked out
  wire read_done = cs_end & (op == `CMD_READ_DATA) & ~ignore &
                   (byte_idx >= 3'd5);
  wire wr_strobe = byte_done & (byte_idx == 3'd3) & ~ignore &
                   (op == `CMD_WRITE_REG);

  // power-up quiet window: the link is deaf until the count expires
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      state    <= ST_INIT;
      init_cnt <= {`INIT_CNT_W{1'b0}};
    end else if (ce) begin
      case (state)
        ST_INIT: begin
          if (init_cnt >= INIT_CYCLES - 1'b1)
            state <= ST_RUN;
          else
            init_cnt <= init_cnt + 1'b1;
        end
        ST_RUN:  state <= ST_RUN;
        default: state <= ST_INIT;
      endcase
    end
  end

  assign link_ready = running;

  // next values of the mode and flag bits
  always @* begin
    next_cont       = mode_continuous;
    next_wake       = mode_wake;
    next_single     = mode_single;
    next_err        = cmd_err;
    next_reset_done = reset_done;
    next_avail      = result_avail;
    next_start      = 1'b0;
    if (meas_done & mode_single)
      next_single = 1'b0;
    if (trig_req & ~any_mode) begin
      next_single = 1'b1;
      next_start  = 1'b1;
    end
    if (cmd_byte) begin
      next_err = reject | trig_rej;
      if (new_op != `CMD_RESET)
        next_reset_done = 1'b0;
    end else if (trig_rej) begin
      next_err = 1'b1;
    end
    if (take_cmd) begin
      case (new_op)
        `CMD_CONTINUOUS: begin
          next_cont  = 1'b1;
          next_start = 1'b1;
        end
        `CMD_WAKE: begin
          next_wake  = 1'b1;
          next_start = 1'b1;
        end
        `CMD_SINGLE: begin
          next_single = 1'b1;
          next_start  = 1'b1;
        end
        `CMD_EXIT: begin
          next_cont   = 1'b0;
          next_wake   = 1'b0;
          next_single = 1'b0;
        end
        default: next_start = next_start;
      endcase
    end
    // clear by a completed read first, so a new result wins
    if (read_done)
      next_avail = 1'b0;
    if ((meas_done & (mode_continuous | mode_single)) |
        (wake_exceed & mode_wake))
      next_avail = 1'b1;
    if (reset_apply) begin
      next_cont       = 1'b0;
      next_wake       = 1'b0;
      next_single     = 1'b0;
      next_err        = 1'b0;
      next_avail      = 1'b0;
      next_start      = 1'b0;
      next_reset_done = 1'b1;
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      mode_continuous <= 1'b0;
      mode_wake       <= 1'b0;
      mode_single     <= 1'b0;
      cmd_err         <= 1'b0;
      reset_done      <= 1'b0;
      result_avail    <= 1'b0;
      meas_start      <= 1'b0;
    end else if (ce) begin
      mode_continuous <= next_cont;
      mode_wake       <= next_wake;
      mode_single     <= next_single;
      cmd_err         <= next_err;
      reset_done      <= next_reset_done;
      result_avail    <= next_avail;
      meas_start      <= next_start;
    end
  end

  // interrupt pin follows the result flag, held until the data is read or a reset command is applied
  assign int_out = result_avail;

  // register read mux; unmapped indices and reserved bits read zero
  always @* begin
    rd_word = 16'h0000;
    case (rx_byte[7:`ADDR_SHIFT])
      `REG_CHIP_STATUS:
        rd_word = {8'h00, mode_continuous, mode_wake, mode_single, cmd_err,
                   2'b00, reset_done, result_avail};
      `REG_ADDRESS_SETTING:
        rd_word[`ADDR_SET_MSB:`ADDR_SET_LSB] = device_address;
      `REG_ANGLE_THRESHOLD:
        rd_word = angle_threshold_value;
      `REG_ADC_SAMPLING_CONTROL: begin
        rd_word[`OSR_MSB:`OSR_LSB]   = oversample_select;
        rd_word[`FILT_MSB:`FILT_LSB] = filter_control;
      end
      `REG_MEASUREMENT_SCHEDULE: begin
        rd_word[`GATE_MSB:`GATE_LSB]         = channel_gate_select;
        rd_word[`INTERVAL_MSB:`INTERVAL_LSB] = interval_count;
      end
      `REG_ANGLE_OFFSET:
        rd_word[`ZERO_MSB:`ZERO_LSB] = angle_zero;
      default: rd_word = 16'h0000;
    endcase
  end

  // configuration registers; a reset command restores them too
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      device_address        <= `RST_ADDR_SET;
      angle_threshold_value <= `RST_THRESHOLD;
      oversample_select     <= `RST_OSR;
      filter_control        <= `RST_FILT;
      channel_gate_select   <= `RST_GATE;
      interval_count        <= `RST_INTERVAL;
      angle_zero            <= `RST_ZERO;
    end else if (ce) begin
      if (reset_apply) begin
        device_address        <= `RST_ADDR_SET;
        angle_threshold_value <= `RST_THRESHOLD;
        oversample_select     <= `RST_OSR;
        filter_control        <= `RST_FILT;
        channel_gate_select   <= `RST_GATE;
        interval_count        <= `RST_INTERVAL;
        angle_zero            <= `RST_ZERO;
      end else if (wr_strobe) begin
        case (rx_byte[7:`ADDR_SHIFT])
          `REG_ADDRESS_SETTING:
            device_address <= wdata[`ADDR_SET_MSB:`ADDR_SET_LSB];
          `REG_ANGLE_THRESHOLD:
            angle_threshold_value <= wdata;
          `REG_ADC_SAMPLING_CONTROL: begin
            oversample_select <= wdata[`OSR_MSB:`OSR_LSB];
            filter_control    <= wdata[`FILT_MSB:`FILT_LSB];
          end
          `REG_MEASUREMENT_SCHEDULE: begin
            channel_gate_select <= wdata[`GATE_MSB:`GATE_LSB];
            interval_count      <= wdata[`INTERVAL_MSB:`INTERVAL_LSB];
          end
          `REG_ANGLE_OFFSET:
            angle_zero <= wdata[`ZERO_MSB:`ZERO_LSB];
          default: angle_zero <= angle_zero;
        endcase
      end
    end
  end

  // frame receive side: bytes sampled on sclk rising edges (mode 3)
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      bit_cnt   <= 3'd0;
      byte_idx  <= 3'd0;
      rx_sh     <= 7'h00;
      cmd       <= 8'h00;
      wdata_hi  <= 8'h00;
      wdata     <= 16'h0000;
      ignore    <= 1'b1;
      reply_en  <= 1'b0;
      stat_snap <= 8'h00;
      word0     <= 16'h0000;
      word1     <= 16'h0000;
    end else if (ce) begin
      if (running & fall[0]) begin
        bit_cnt  <= 3'd0;
        byte_idx <= 3'd0;
        reply_en <= 1'b0;
        ignore   <= 1'b0;
      end else if (cs_end) begin
        reply_en <= 1'b0;
      end else if (cs_act & rise[1]) begin
        rx_sh   <= rx_byte[6:0];
        bit_cnt <= bit_cnt + 3'd1;
        if (byte_done & (byte_idx != 3'd7))
          byte_idx <= byte_idx + 3'd1;
      end
      if (cmd_byte) begin
        cmd      <= rx_byte;
        // a reset frame must stay live so that its end applies the reset
        ignore   <= reject;
        // a reset command is answered by nothing at all
        reply_en <= (new_op != `CMD_RESET);
        stat_snap <= {next_cont, next_wake, next_single,
                      next_err, 2'b00, reset_done, next_avail};
        if (new_op == `CMD_READ_DATA) begin
          word0 <= angle_data;
          word1 <= field_data;
        end
      end
      if (byte_done & ~ignore & (byte_idx == 3'd1)) begin
        if (op == `CMD_READ_REG)
          word0 <= rd_word;
        wdata_hi <= rx_byte;
      end
      if (byte_done & ~ignore & (byte_idx == 3'd2))
        wdata <= {wdata_hi, rx_byte};
    end
  end

  // reply byte for the byte slot now starting
  always @* begin
    case (byte_idx)
      3'd1:    tx_sel = stat_snap;
      3'd2:    tx_sel = word0[15:8];
      3'd3:    tx_sel = word0[7:0];
      3'd4:    tx_sel = word1[15:8];
      3'd5:    tx_sel = word1[7:0];
      default: tx_sel = 8'h00;
    endcase
  end

  // mode 3: data changes on falling edges, msb first
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      tx_sh  <= 8'h00;
      miso_q <= 1'b0;
    end else if (ce) begin
      if (cs_act & fall[1]) begin
        if (bit_cnt == 3'd0) begin
          miso_q <= tx_sel[7];
          tx_sh  <= {tx_sel[6:0], 1'b0};
        end else begin
          miso_q <= tx_sh[7];
          tx_sh  <= {tx_sh[6:0], 1'b0};
        end
      end
    end
  end

  assign spi_miso_out  = miso_q;
  assign spi_miso_oe_n = ~(cs_act & reply_en);

endmodule

`default_nettype wire
